/* design/sspbg_pkg.sv */
// Package for the sync serial port baud generator and first control register.
// Assumes a single 250 MHz clock and a simple strobe register port.
`default_nettype none
package sspbg_pkg;
	localparam logic [11:0] ADDR_CTRL_ONE  = 12'h190;
	localparam logic [11:0] ADDR_RELOAD    = 12'h191;
	localparam logic [11:0] ADDR_XFER_BUF  = 12'h192;
	localparam logic [11:0] ADDR_IRQ_STAT  = 12'h193;
	localparam logic [11:0] ADDR_IRQ_CLR   = 12'h194;
	localparam logic [11:0] ADDR_IRQ_EN    = 12'h195;
	localparam logic [11:0] ADDR_BUS_STAT  = 12'h196;
	localparam int          BIT_WRITE_COLLISION_FLAG       = 7;
	localparam int          BIT_OVF        = 6;
	localparam int          BIT_EN         = 5;
	localparam int          BIT_POL        = 4;
	localparam logic [7:0]  CTRL_RST       = 8'h00;
	localparam logic [7:0]  RELOAD_RST     = 8'h00;
	localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
	// Mode select encodings
	localparam logic [3:0]  MODE_SPI_M0    = 4'h0;
	localparam logic [3:0]  MODE_SPI_M3    = 4'h3;
	localparam logic [3:0]  MODE_SPI_S0    = 4'h4;
	localparam logic [3:0]  MODE_SPI_S1    = 4'h5;
	localparam logic [3:0]  MODE_I2C_S7    = 4'h6;
	localparam logic [3:0]  MODE_I2C_S10   = 4'h7;
	localparam logic [3:0]  MODE_I2C_M     = 4'h8;
	// Interrupt status bit positions
	localparam int          IRQ_DONE       = 0;
	localparam int          IRQ_WRITE_COLLISION_FLAG       = 1;
	localparam int          IRQ_OVF        = 2;
	localparam int          IRQ_BCOL       = 3;
	typedef enum logic [1:0] {BG_IDLE, BG_RUN, BG_STOPCHK} sspbg_state_type;
endpackage
`default_nettype wire

/* design/sspbg_top.sv */
// Baud generator, shifter and control register of the sync serial port.
// Assumes registers are reached by a one-cycle strobe port; pins come in asynchronous.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module sspbg_top (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [7:0]  rdata_o,
	input  wire logic        sck_in_i,
	output logic             sck_o,
	output logic             sck_oe_o,
	input  wire logic        sda_in_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        bus_idle_i,
	input  wire logic        stop_req_i,
	output logic             irq_o
);

	////////////////////////////////////////////////////////////////////////
	logic [7:0]                     ctrl_ff;
	logic [7:0]                     reload_ff;
	logic [7:0]                     cnt_ff;
	logic [7:0]                     shift_ff;
	logic [7:0]                     rxbuf_ff;
	logic                           full_ff;
	logic [3:0]                     bits_ff;
	logic                           phase_ff;
	logic                           busy_ff;
	sspbg_pkg::sspbg_state_type     state_ff;
	logic [3:0]                     ist_ff;
	logic [3:0]                     ien_ff;
	logic                           bcol_ff;
	logic [1:0]                     sck_sync_ff;
	logic [1:0]                     sda_sync_ff;
	logic [1:0]                     sck_hist_ff;
	logic                           done_ev;
	logic                           write_collision_flag_ev;
	logic                           ovf_ev;
	logic                           bcol_ev;
	logic                           reload_pulse;
	logic                           buf_wr;
	logic                           buf_rd;
	logic [3:0]                     mode;
	logic                           is_master;
	logic                           is_spi_slave;
	logic                           is_i2c_slave;
	logic                           slave_edge;

	assign mode         = ctrl_ff[3:0];
	assign is_master    = (mode <= sspbg_pkg::MODE_SPI_M3) || (mode == sspbg_pkg::MODE_I2C_M);
	assign is_spi_slave = (mode == sspbg_pkg::MODE_SPI_S0) || (mode == sspbg_pkg::MODE_SPI_S1);
	assign is_i2c_slave = (mode == sspbg_pkg::MODE_I2C_S7) || (mode == sspbg_pkg::MODE_I2C_S10);
	assign buf_wr       = wr_i && (addr_i == sspbg_pkg::ADDR_XFER_BUF);
	assign buf_rd       = rd_i && (addr_i == sspbg_pkg::ADDR_XFER_BUF);
	assign slave_edge   = (sck_hist_ff == 2'b01) && ctrl_ff[sspbg_pkg::BIT_EN] && !is_master;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			// Idle clock pin is pulled high, so no false edge after reset
			sck_sync_ff <= 2'b11;
			sda_sync_ff <= 2'b11;
			sck_hist_ff <= 2'b11;
		end
		else
		begin
			sck_sync_ff <= {sck_sync_ff[0], sck_in_i};
			sda_sync_ff <= {sda_sync_ff[0], sda_in_i};
			sck_hist_ff <= {sck_hist_ff[0], sck_sync_ff[1]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Collision events per mode
	always_comb
	begin
		write_collision_flag_ev = 1'b0;
		if (buf_wr && ctrl_ff[sspbg_pkg::BIT_EN])
		begin
			if (mode == sspbg_pkg::MODE_I2C_M)
				write_collision_flag_ev = busy_ff || !bus_idle_i;
			else
				write_collision_flag_ev = busy_ff;
		end
	end

	assign ovf_ev  = done_ev && full_ff && (is_spi_slave || is_i2c_slave || mode == sspbg_pkg::MODE_I2C_M);
	assign bcol_ev = (state_ff == sspbg_pkg::BG_STOPCHK) && (cnt_ff == 8'h00) && !sda_sync_ff[1];

	////////////////////////////////////////////////////////////////////////
	// control register, hardware set wins over software write
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			ctrl_ff <= sspbg_pkg::CTRL_RST;
		else
		begin
			if (wr_i && addr_i == sspbg_pkg::ADDR_CTRL_ONE)
				ctrl_ff <= wdata_i;
			if (write_collision_flag_ev)
				ctrl_ff[sspbg_pkg::BIT_WRITE_COLLISION_FLAG] <= 1'b1;
			if (ovf_ev)
				ctrl_ff[sspbg_pkg::BIT_OVF] <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			reload_ff <= sspbg_pkg::RELOAD_RST;
		else if (wr_i && addr_i == sspbg_pkg::ADDR_RELOAD)
			reload_ff <= wdata_i;
	end

	////////////////////////////////////////////////////////////////////////
	// zero count reloads while transfer runs
	assign reload_pulse = (state_ff == sspbg_pkg::BG_RUN) && (cnt_ff == 8'h00);

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			state_ff <= sspbg_pkg::BG_IDLE;
			cnt_ff   <= 8'h00;
			phase_ff <= 1'b0;
			busy_ff  <= 1'b0;
			bits_ff  <= 4'h0;
			shift_ff <= 8'h00;
		end
		else
		begin
			case (state_ff)
				sspbg_pkg::BG_IDLE:
				begin
					phase_ff <= ctrl_ff[sspbg_pkg::BIT_POL];
					if (buf_wr && !write_collision_flag_ev && ctrl_ff[sspbg_pkg::BIT_EN] && is_master)
					begin
						state_ff <= sspbg_pkg::BG_RUN;
						cnt_ff   <= reload_ff;
						busy_ff  <= 1'b1;
						bits_ff  <= 4'h0;
						shift_ff <= wdata_i;
					end
					else if (buf_wr && !write_collision_flag_ev && ctrl_ff[sspbg_pkg::BIT_EN])
					begin
						busy_ff  <= 1'b1;
						bits_ff  <= 4'h0;
						shift_ff <= wdata_i;
					end
					// stop needs one countdown then check
					else if (stop_req_i && mode == sspbg_pkg::MODE_I2C_M && ctrl_ff[sspbg_pkg::BIT_EN])
					begin
						state_ff <= sspbg_pkg::BG_STOPCHK;
						cnt_ff   <= reload_ff;
					end
					if (slave_edge)
					begin
						shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
						bits_ff  <= bits_ff + 4'h1;
						if (bits_ff == sspbg_pkg::BITS_PER_BYTE - 4'h1)
						begin
							bits_ff <= 4'h0;
							busy_ff <= 1'b0;
						end
					end
				end
				sspbg_pkg::BG_RUN:
				begin
					if (reload_pulse)
					begin
						cnt_ff   <= reload_ff;
						phase_ff <= !phase_ff;
						if (phase_ff != ctrl_ff[sspbg_pkg::BIT_POL])
						begin
							shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
							bits_ff  <= bits_ff + 4'h1;
							// stop after last bit, clock held
							if (bits_ff == sspbg_pkg::BITS_PER_BYTE - 4'h1)
							begin
								state_ff <= sspbg_pkg::BG_IDLE;
								busy_ff  <= 1'b0;
								bits_ff  <= 4'h0;
							end
						end
					end
					else
						cnt_ff <= cnt_ff - 8'h01;
				end
				sspbg_pkg::BG_STOPCHK:
				begin
					if (cnt_ff == 8'h00)
						state_ff <= sspbg_pkg::BG_IDLE;
					else
						cnt_ff <= cnt_ff - 8'h01;
				end
				default:
					state_ff <= sspbg_pkg::BG_IDLE;
			endcase
		end
	end

	assign done_ev = (bits_ff == sspbg_pkg::BITS_PER_BYTE - 4'h1) &&
		((busy_ff && reload_pulse && phase_ff != ctrl_ff[sspbg_pkg::BIT_POL]) ||
		(slave_edge && state_ff == sspbg_pkg::BG_IDLE));

	// Receive buffer holds byte until software reads it
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			rxbuf_ff <= 8'h00;
			full_ff  <= 1'b0;
		end
		else if (done_ev && !full_ff)
		begin
			rxbuf_ff <= {shift_ff[6:0], sda_sync_ff[1]};
			full_ff  <= 1'b1;
		end
		else if (buf_rd)
			full_ff <= 1'b0;
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			bcol_ff <= 1'b0;
		else if (bcol_ev)
			bcol_ff <= 1'b1;
		else if (wr_i && addr_i == sspbg_pkg::ADDR_BUS_STAT)
			bcol_ff <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status, set wins over clear
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			ist_ff <= 4'h0;
			ien_ff <= 4'h0;
			irq_o  <= 1'b0;
		end
		else
		begin
			if (wr_i && addr_i == sspbg_pkg::ADDR_IRQ_EN)
				ien_ff <= wdata_i[3:0];
			ist_ff <= ((wr_i && addr_i == sspbg_pkg::ADDR_IRQ_CLR) ? (ist_ff & ~wdata_i[3:0]) : ist_ff)
				| {bcol_ev, ovf_ev, write_collision_flag_ev, done_ev};
			irq_o  <= |(ist_ff & ien_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pins and read port
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			sck_o    <= 1'b0;
			sck_oe_o <= 1'b0;
			sda_o    <= 1'b1;
			sda_oe_o <= 1'b0;
			rdata_o  <= 8'h00;
		end
		else
		begin
			sck_o    <= phase_ff;
			sck_oe_o <= ctrl_ff[sspbg_pkg::BIT_EN] && is_master;
			sda_o    <= shift_ff[7];
			sda_oe_o <= ctrl_ff[sspbg_pkg::BIT_EN] && busy_ff;
			rdata_o  <= 8'h00;
			if (rd_i)
			begin
				case (addr_i)
					sspbg_pkg::ADDR_CTRL_ONE: rdata_o <= ctrl_ff;
					sspbg_pkg::ADDR_RELOAD:   rdata_o <= reload_ff;
					sspbg_pkg::ADDR_XFER_BUF: rdata_o <= rxbuf_ff;
					sspbg_pkg::ADDR_IRQ_STAT: rdata_o <= {4'h0, ist_ff};
					sspbg_pkg::ADDR_IRQ_EN:   rdata_o <= {4'h0, ien_ff};
					sspbg_pkg::ADDR_BUS_STAT: rdata_o <= {6'h00, busy_ff, bcol_ff};
					default:                  rdata_o <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_write_collision_flag_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
		write_collision_flag_ev |=> ctrl_ff[sspbg_pkg::BIT_WRITE_COLLISION_FLAG]) else $error("collision flag not set");
	a_ovf_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
		ovf_ev |=> ctrl_ff[sspbg_pkg::BIT_OVF]) else $error("overflow flag not set");
	a_start_load: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_ff == sspbg_pkg::BG_IDLE && buf_wr && !write_collision_flag_ev && ctrl_ff[5] && is_master)
		|=> (state_ff == sspbg_pkg::BG_RUN && cnt_ff == $past(reload_ff))) else $error("start failed");
	a_reload_val: assert property (@(posedge mclk_i) disable iff (rst_i)
		reload_pulse |=> cnt_ff == $past(reload_ff)) else $error("reload wrong");
	a_phase_toggle: assert property (@(posedge mclk_i) disable iff (rst_i)
		reload_pulse |=> phase_ff != $past(phase_ff)) else $error("phase not toggled");
	a_clock_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_ff != sspbg_pkg::BG_RUN && $stable(ctrl_ff)) |=> $stable(phase_ff)) else $error("clock moved idle");
	a_sck_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
		1'b1 |=> sck_o == $past(phase_ff)) else $error("sck mismatch");
	a_i2cm_write_collision_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
		(buf_wr && ctrl_ff[5] && mode == sspbg_pkg::MODE_I2C_M && !bus_idle_i) |-> write_collision_flag_ev) else $error("i2c write_collision_flag");
	a_stop_bcol: assert property (@(posedge mclk_i) disable iff (rst_i)
		bcol_ev |=> bcol_ff ##1 ist_ff[sspbg_pkg::IRQ_BCOL]) else $error("bus collision lost");
	a_ctrl_write: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_i && addr_i == sspbg_pkg::ADDR_CTRL_ONE && !write_collision_flag_ev && !ovf_ev) |=> ctrl_ff == $past(wdata_i))
		else $error("ctrl write lost");
	c_master_byte: cover property (@(posedge mclk_i) done_ev && is_master);
	c_write_collision_flag: cover property (@(posedge mclk_i) write_collision_flag_ev);
	c_ovf: cover property (@(posedge mclk_i) ovf_ev);
	c_bcol: cover property (@(posedge mclk_i) bcol_ev);

endmodule // sspbg_top
`default_nettype wire

/* dv/sspbg_bus_model.sv */
// Far-side bus model: pull-ups, external clock source and data level.
// Assumes the bench moves its control inputs just after mclk edges.
`timescale 1ns/100ps
`default_nettype none
module sspbg_bus_model (
	input  wire logic       dut_sck_i,
	input  wire logic       dut_sck_oe_i,
	input  wire logic       dut_sda_i,
	input  wire logic       dut_sda_oe_i,
	input  wire logic       ext_clk_i,
	input  wire logic       sda_lvl_i,
	output logic            sck_in_o,
	output logic            sda_in_o,
	output logic      [7:0] cap_o
);
	// Released clock goes to pull-up or external clock
	assign sck_in_o = dut_sck_oe_i ? dut_sck_i : ext_clk_i;
	// Far side may hold data low
	assign sda_in_o = dut_sda_oe_i ? dut_sda_i : sda_lvl_i;
	// Capture only what the block clocks out
	initial
	begin
		cap_o = 8'h00;
		forever
		begin
			@(posedge sck_in_o);
			if (dut_sck_oe_i)
				cap_o <= {cap_o[6:0], sda_in_o};
		end
	end
endmodule // sspbg_bus_model
`default_nettype wire

/* dv/test_sspbg_top.sv */
// Bench for the baud generator and first control register.
// Assumes the design package and top are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_sspbg_top;
	logic        mclk_i     = 1'b0;
	logic        rst_i      = 1'b1;
	logic [11:0] addr_i     = 12'h000;
	logic [7:0]  wdata_i    = 8'h00;
	logic        wr_i       = 1'b0;
	logic        rd_i       = 1'b0;
	logic        bus_idle_i = 1'b1;
	logic        stop_req_i = 1'b0;
	logic        ext_clk    = 1'b1;
	logic        sda_lvl    = 1'b1;
	logic [7:0]  rdata_o;
	logic [7:0]  cap;
	logic [7:0]  rv;
	logic        sck_in_i, sck_o, sck_oe_o, sda_in_i, sda_o, sda_oe_o, irq_o;
	int          err_total  = 0;
	int          n_checks   = 0;

	always #2 mclk_i = ~mclk_i;

	sspbg_top i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sck_in_i(sck_in_i), .sck_o(sck_o),
		.sck_oe_o(sck_oe_o), .sda_in_i(sda_in_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.bus_idle_i(bus_idle_i), .stop_req_i(stop_req_i), .irq_o(irq_o));

	sspbg_bus_model i_bus (.dut_sck_i(sck_o), .dut_sck_oe_i(sck_oe_o), .dut_sda_i(sda_o),
		.dut_sda_oe_i(sda_oe_o), .ext_clk_i(ext_clk), .sda_lvl_i(sda_lvl),
		.sck_in_o(sck_in_i), .sda_in_o(sda_in_i), .cap_o(cap));

	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i    <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [11:0] a);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge mclk_i);
		rd_i   <= 1'b0;
		#1 rv = rdata_o;
	endtask

	task automatic pulses(input int n);
		repeat (n)
		begin
			ext_clk <= 1'b0;
			cyc(4);
			ext_clk <= 1'b1;
			cyc(4);
		end
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		reg_rd(sspbg_pkg::ADDR_CTRL_ONE); chk8(rv, 8'h00);
		reg_rd(sspbg_pkg::ADDR_RELOAD); chk8(rv, 8'h00);
		reg_rd(12'h1ff); chk8(rv, 8'h00);
		reg_wr(sspbg_pkg::ADDR_CTRL_ONE, 8'h3a);
		reg_rd(sspbg_pkg::ADDR_CTRL_ONE); chk8(rv, 8'h3a);
	endtask

	task automatic t_master();
		int   n;
		int   t0;
		int   t1;
		logic last;
		reg_wr(sspbg_pkg::ADDR_RELOAD, 8'h02);
		reg_wr(sspbg_pkg::ADDR_CTRL_ONE, 8'h20);
		reg_wr(sspbg_pkg::ADDR_XFER_BUF, 8'ha5);
		// Let the edge that launches the clock level settle
		#1 last = sck_o;
		n = 0;
		t0 = 0;
		t1 = 0;
		for (int c = 0; c < 200; c++)
		begin
			@(posedge mclk_i);
			#1;
			if (sck_o !== last)
			begin
				n++;
				if (n == 2)
					t0 = c;
				if (n == 3)
					t1 = c;
				last = sck_o;
			end
		end
		chk8(8'(n), 8'h10);
		chk8(8'(t1 - t0), 8'h03);
		chk8(cap, 8'ha5);
		reg_rd(sspbg_pkg::ADDR_IRQ_STAT); chk8(rv, 8'h01);
		chk8({7'h00, irq_o}, 8'h00);
		reg_wr(sspbg_pkg::ADDR_IRQ_EN, 8'h01);
		cyc(2); chk8({7'h00, irq_o}, 8'h01);
		reg_wr(sspbg_pkg::ADDR_IRQ_CLR, 8'h0f);
		cyc(2); chk8({7'h00, irq_o}, 8'h00);
		reg_wr(sspbg_pkg::ADDR_IRQ_EN, 8'h00);
	endtask

	task automatic t_write_collision_flag();
		reg_wr(sspbg_pkg::ADDR_XFER_BUF, 8'h5a);
		reg_wr(sspbg_pkg::ADDR_XFER_BUF, 8'hff);
		reg_rd(sspbg_pkg::ADDR_IRQ_STAT); chk8(rv, 8'h02);
		cyc(200);
		reg_rd(sspbg_pkg::ADDR_CTRL_ONE); chk8(rv, 8'ha0);
		reg_wr(sspbg_pkg::ADDR_CTRL_ONE, 8'h28);
		bus_idle_i <= 1'b0;
		reg_wr(sspbg_pkg::ADDR_XFER_BUF, 8'h11);
		cyc(2); chk8({7'h00, sck_oe_o}, 8'h01);
		reg_rd(sspbg_pkg::ADDR_BUS_STAT); chk8(rv, 8'h00);
		reg_rd(sspbg_pkg::ADDR_CTRL_ONE); chk8(rv, 8'ha8);
		bus_idle_i <= 1'b1;
		// Far clock low before release, so no false edge
		ext_clk    <= 1'b0;
		reg_wr(sspbg_pkg::ADDR_CTRL_ONE, 8'h26);
		reg_wr(sspbg_pkg::ADDR_XFER_BUF, 8'h3c);
		pulses(4);
		chk8({7'h00, sda_oe_o}, 8'h01);
		reg_wr(sspbg_pkg::ADDR_XFER_BUF, 8'hc3);
		reg_rd(sspbg_pkg::ADDR_CTRL_ONE); chk8(rv, 8'ha6);
		pulses(4);
		reg_wr(sspbg_pkg::ADDR_CTRL_ONE, 8'h00);
	endtask

	task automatic t_ovf(input logic [3:0] mode);
		reg_wr(sspbg_pkg::ADDR_CTRL_ONE, {4'h2, mode});
		reg_rd(sspbg_pkg::ADDR_XFER_BUF);
		pulses(8);
		reg_rd(sspbg_pkg::ADDR_CTRL_ONE); chk8(rv, {4'h2, mode});
		pulses(8);
		reg_rd(sspbg_pkg::ADDR_CTRL_ONE); chk8(rv, {4'h6, mode});
		reg_wr(sspbg_pkg::ADDR_CTRL_ONE, 8'h00);
	endtask

	task automatic t_bcol();
		reg_wr(sspbg_pkg::ADDR_IRQ_CLR, 8'h0f);
		reg_wr(sspbg_pkg::ADDR_CTRL_ONE, 8'h28);
		sda_lvl    <= 1'b0;
		stop_req_i <= 1'b1;
		cyc(1);
		stop_req_i <= 1'b0;
		cyc(20);
		reg_rd(sspbg_pkg::ADDR_BUS_STAT); chk8(rv, 8'h01);
		reg_rd(sspbg_pkg::ADDR_IRQ_STAT); chk8(rv, 8'h08);
		sda_lvl <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		cyc(5);
		rst_i <= 1'b0;
		t_regs();
		t_master();
		t_write_collision_flag();
		t_ovf(sspbg_pkg::MODE_SPI_S0);
		t_ovf(sspbg_pkg::MODE_I2C_S7);
		t_bcol();
		wrap_up();
	end

	initial
	begin
		cyc(20000);
		err_total++;
		wrap_up();
	end
endmodule // test_sspbg_top
`default_nettype wire
